// ==== hdl/crc_pkg.sv ====
// Package with register map, field layout and constants of the CRC unit
package crc_pkg;
    // Register addresses on the special function register bus
    localparam logic [7:0] CRC_CONTROL_ADDR   = 8'h91;
    localparam logic [7:0] CRC_INPUT_ADDR     = 8'h94;
    localparam logic [7:0] CRC_RESULT_ADDR    = 8'hd9;
    localparam logic [7:0] CRC_AUTO_ADDR      = 8'hd2;
    localparam logic [7:0] CRC_COUNT_ADDR     = 8'hd3;
    // Control register fields
    localparam int         CTL_POLY_BIT       = 4;
    localparam int         CTL_INIT_BIT       = 3;
    localparam int         CTL_VAL_BIT        = 2;
    localparam int         CTL_PNT_LSB        = 0;
    localparam logic [7:0] CTL_RESET          = 8'h00;
    // Auto control register fields
    localparam int         AUTO_EN_BIT        = 7;
    localparam logic [7:0] AUTO_RESET         = 8'h00;
    localparam logic [7:0] COUNT_RESET        = 8'h00;
    // Polynomials and start values
    localparam logic [31:0] POLY32_NORMAL     = 32'h04c11db7;
    localparam logic [31:0] POLY32_REFLECTED  = 32'hedb88320;
    localparam logic [15:0] POLY16            = 16'h1021;
    localparam logic [31:0] INIT_ZEROS        = 32'h00000000;
    localparam logic [31:0] INIT_ONES         = 32'hffffffff;
    localparam logic [31:0] RESULT_RESET      = 32'h00000000;
    // Flash geometry
    localparam int          SECTOR_BYTES      = 512;
    localparam int          SECTOR_ADDR_BITS  = 9;
    localparam int          FLASH_ADDR_BITS   = 16;
    typedef enum logic [1:0] {AUTO_IDLE, AUTO_REQ, AUTO_FEED} crc_auto_state_t;
endpackage : crc_pkg

// ==== hdl/crc_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module crc_fifo
    import crc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             inValid,
    output      logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output      logic             outValid,
    input  wire logic             outReady,
    output      logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doPush) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doPop) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule : crc_fifo

// ==== hdl/crc_unit.sv ====
// CRC unit: control registers, byte engine, result port and flash auto run
`timescale 1ns/10ps
module crc_unit
    import crc_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Special function register bus
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrWdata,
    output      logic [7:0]  sfrRdata,
    output      logic        sfrReady,
    // Processor stall
    output      logic        cpuStall,
    // Flash read port
    output      logic        flashRead,
    output      logic [15:0] flashAddr,
    input  wire logic        flashValid,
    input  wire logic [7:0]  flashData
);
    // Register state
    logic                    polySel_reg;
    logic                    initSel_reg;
    logic [1:0]              pointer_reg;
    logic [31:0]             result_reg;
    logic [31:0]             result_next;
    logic [7:0]              autoCtl_reg;
    logic [7:0]              sectorCnt_reg;
    logic [7:0]              rdata_reg;
    crc_auto_state_t         state_reg;
    logic [FLASH_ADDR_BITS-1:0] addr_reg;
    logic [FLASH_ADDR_BITS-1:0] remaining_reg;
    logic                    reqPending_reg;

    // Decode
    wire wrCtl    = sfrWrite && (sfrAddr == CRC_CONTROL_ADDR);
    wire wrIn     = sfrWrite && (sfrAddr == CRC_INPUT_ADDR);
    wire wrRes    = sfrWrite && (sfrAddr == CRC_RESULT_ADDR);
    wire rdRes    = sfrRead && (sfrAddr == CRC_RESULT_ADDR);
    wire wrAuto   = sfrWrite && (sfrAddr == CRC_AUTO_ADDR);
    wire wrCount  = sfrWrite && (sfrAddr == CRC_COUNT_ADDR);
    wire auto_run_enable   = autoCtl_reg[AUTO_EN_BIT];
    wire running  = (state_reg != AUTO_IDLE);
    wire initReq  = wrCtl && sfrWdata[CTL_INIT_BIT];
    // Next pointer and mode come from the write itself when control is written
    wire newPoly  = wrCtl ? sfrWdata[CTL_POLY_BIT] : polySel_reg;
    wire newVal   = wrCtl ? sfrWdata[CTL_VAL_BIT] : initSel_reg;
    wire [31:0] newInit = newVal ? INIT_ONES : INIT_ZEROS;
    wire startRun = wrCtl && auto_run_enable && !running && (sectorCnt_reg != 8'h00);

    // Byte source: software writes, or flash bytes during an automatic run
    logic       fifoInValid;
    logic       fifoInReady;
    logic [7:0] fifoInData;
    logic       fifoOutValid;
    logic [7:0] fifoOutData;
    assign fifoInValid = wrIn || (running && flashValid);
    assign fifoInData  = wrIn ? sfrWdata : flashData;

    crc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) i_crc_fifo (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (fifoOutValid),
        .outReady (1'b1),
        .outData  (fifoOutData)
    );

    // One byte through the selected polynomial
    function automatic logic [31:0] crc_step(input logic [31:0] acc, input logic [7:0] data,
                                             input logic poly16);
        logic [31:0] a;
        logic [15:0] b;
        a = acc ^ {24'h000000, data};
        b = acc[15:0] ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            a = a[0] ? ((a >> 1) ^ POLY32_REFLECTED) : (a >> 1);
            b = b[15] ? ((b << 1) ^ POLY16) : (b << 1);
        end
        crc_step = poly16 ? {acc[31:16], b} : a;
    endfunction : crc_step

    // Selects the result byte a pointer value addresses
    function automatic logic [1:0] byte_index(input logic [1:0] pnt, input logic poly16);
        byte_index = poly16 ? {1'b0, pnt[0]} : pnt;
    endfunction : byte_index

    wire [1:0]  resIdx  = byte_index(pointer_reg, polySel_reg);
    wire [31:0] crcNew  = crc_step(result_reg, fifoOutData, polySel_reg);
    wire [31:0] byteMask = 32'h000000ff << {resIdx, 3'b000};
    wire [31:0] byteWr  = (result_reg & ~byteMask) | ({24'h000000, sfrWdata} << {resIdx, 3'b000});

    // Result update: init wins, then byte write, then engine
    always_comb begin
        result_next = result_reg;
        if (fifoOutValid) begin
            result_next = crcNew;
        end
        if (wrRes) begin
            result_next = byteWr;
        end
        if (initReq) begin
            result_next = newInit;
        end
    end

    // Read data mux
    wire [7:0] ctlRead = {3'b000, polySel_reg, 1'b0, initSel_reg, pointer_reg};
    wire [7:0] resRead = result_reg[{resIdx, 3'b000} +: 8];
    logic [7:0] readMux;
    always_comb begin
        case (sfrAddr)
            CRC_CONTROL_ADDR: readMux = ctlRead;
            CRC_RESULT_ADDR:  readMux = resRead;
            CRC_AUTO_ADDR:    readMux = autoCtl_reg;
            CRC_COUNT_ADDR:   readMux = sectorCnt_reg;
            default:          readMux = 8'h00;
        endcase
    end

    assign sfrRdata = rdata_reg;
    assign sfrReady = 1'b1;
    // Stall while the run is active or bytes still wait in the FIFO
    assign cpuStall = running || fifoOutValid;
    assign flashRead = reqPending_reg;
    assign flashAddr = addr_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            polySel_reg <= CTL_RESET[CTL_POLY_BIT];
            initSel_reg <= CTL_RESET[CTL_VAL_BIT];
            pointer_reg <= CTL_RESET[CTL_PNT_LSB +: 2];
            result_reg  <= RESULT_RESET;
            rdata_reg   <= 8'h00;
        end else begin
            result_reg <= result_next;
            rdata_reg  <= sfrRead ? readMux : rdata_reg;
            if (wrCtl) begin
                polySel_reg <= newPoly;
                initSel_reg <= newVal;
                pointer_reg <= sfrWdata[CTL_PNT_LSB +: 2];
            end else if (wrRes || rdRes) begin
                pointer_reg <= pointer_reg + 2'b01;
            end
        end
    end

    // Automatic flash run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            autoCtl_reg    <= AUTO_RESET;
            sectorCnt_reg  <= COUNT_RESET;
            state_reg      <= AUTO_IDLE;
            addr_reg       <= '0;
            remaining_reg  <= '0;
            reqPending_reg <= 1'b0;
        end else begin
            if (wrAuto) begin
                autoCtl_reg <= sfrWdata;
            end
            if (wrCount) begin
                sectorCnt_reg <= sfrWdata;
            end
            case (state_reg)
                AUTO_IDLE: begin
                    reqPending_reg <= 1'b0;
                    if (startRun) begin
                        addr_reg      <= {autoCtl_reg[6:0], {SECTOR_ADDR_BITS{1'b0}}};
                        remaining_reg <= FLASH_ADDR_BITS'(sectorCnt_reg) * FLASH_ADDR_BITS'(SECTOR_BYTES);
                        state_reg     <= AUTO_REQ;
                    end
                end
                AUTO_REQ: begin
                    if (fifoInReady) begin
                        reqPending_reg <= 1'b1;
                        state_reg      <= AUTO_FEED;
                    end
                end
                AUTO_FEED: begin
                    reqPending_reg <= 1'b0;
                    if (flashValid) begin
                        addr_reg      <= addr_reg + 1'b1;
                        remaining_reg <= remaining_reg - 1'b1;
                        state_reg     <= (remaining_reg == 16'h0001) ? AUTO_IDLE : AUTO_REQ;
                    end
                end
                default: state_reg <= AUTO_IDLE;
            endcase
        end
    end

    // Checks
    sequence s_initWrite;
        initReq && !newVal;
    endsequence
    property p_initZero;
        @(posedge clk) disable iff (!resetn) s_initWrite |=> (result_reg == INIT_ZEROS);
    endproperty
    a_initZero: assert property (p_initZero) else $error("init zero failed");
    property p_initOnes;
        @(posedge clk) disable iff (!resetn)
            (initReq && newVal) |=> (result_reg == INIT_ONES);
    endproperty
    a_initOnes: assert property (p_initOnes) else $error("init ones failed");
    property p_engine;
        @(posedge clk) disable iff (!resetn)
            (fifoOutValid && !wrRes && !initReq) |=> (result_reg == $past(crcNew));
    endproperty
    a_engine: assert property (p_engine) else $error("engine update failed");
    property p_hold;
        @(posedge clk) disable iff (!resetn)
            (!fifoOutValid && !wrRes && !initReq) |=> $stable(result_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed");
    property p_ptrInc;
        @(posedge clk) disable iff (!resetn)
            ((wrRes || rdRes) && !wrCtl) |=> (pointer_reg == $past(pointer_reg) + 2'b01);
    endproperty
    a_ptrInc: assert property (p_ptrInc) else $error("pointer no increment");
    property p_unused;
        @(posedge clk) disable iff (!resetn)
            (sfrRead && (sfrAddr == CRC_CONTROL_ADDR)) |=> (sfrRdata[7:5] == 3'b000);
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits set");
    property p_upper16;
        @(posedge clk) disable iff (!resetn)
            (polySel_reg && fifoOutValid && !wrRes && !initReq)
                |=> (result_reg[31:16] == $past(result_reg[31:16]));
    endproperty
    a_upper16: assert property (p_upper16) else $error("16-bit mode touched top");
    sequence s_start;
        startRun;
    endsequence
    property p_stall;
        @(posedge clk) disable iff (!resetn) s_start |=> cpuStall [*2];
    endproperty
    a_stall: assert property (p_stall) else $error("no stall during run");
    property p_alias;
        @(posedge clk) disable iff (!resetn)
            (rdRes && polySel_reg)
                |=> (sfrRdata == ($past(pointer_reg[0]) ? $past(result_reg[15:8])
                                                        : $past(result_reg[7:0])));
    endproperty
    a_alias: assert property (p_alias) else $error("16-bit alias wrong");

    // Bytes taken from flash in the current run, for the run length check
    logic [FLASH_ADDR_BITS-1:0] runBytes_reg;
    logic [7:0]                 runSectors_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            runBytes_reg   <= '0;
            runSectors_reg <= 8'h00;
        end else if (startRun) begin
            runBytes_reg   <= '0;
            runSectors_reg <= sectorCnt_reg;
        end else if (running && flashValid) begin
            runBytes_reg <= runBytes_reg + 1'b1;
        end
    end
    sequence s_firstReq;
        ##1 (flashRead && (flashAddr == {$past(autoCtl_reg[6:0], 2), {SECTOR_ADDR_BITS{1'b0}}}));
    endsequence
    property p_firstReq;
        @(posedge clk) disable iff (!resetn) s_start |=> s_firstReq;
    endproperty
    a_firstReq: assert property (p_firstReq) else $error("first flash request wrong");
    property p_runLength;
        @(posedge clk) disable iff (!resetn)
            $fell(running) |-> (runBytes_reg == FLASH_ADDR_BITS'(runSectors_reg)
                                                * FLASH_ADDR_BITS'(SECTOR_BYTES));
    endproperty
    a_runLength: assert property (p_runLength) else $error("run length wrong");
endmodule : crc_unit

// ==== dv/crc_flash_model.sv ====
// Flash memory model answering byte reads promptly or slowly
`timescale 1ns/10ps
module crc_flash_model (
    // Clock, reset and delay select
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    // Flash read port
    input  wire logic        flashRead,
    input  wire logic [15:0] flashAddr,
    output      logic        flashValid,
    output      logic [7:0]  flashData,
    output      int          readCount
);
    logic [15:0] addrReg;
    logic [1:0]  waitCnt;
    logic        busy;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            flashValid <= 1'b0;
            flashData <= 8'h00;
            readCount <= 0;
        end else begin
            flashValid <= 1'b0;
            // Data line toggles whenever no byte is being delivered
            flashData <= ~flashData;
            if (flashRead) begin
                busy <= 1'b1;
                addrReg <= flashAddr;
                waitCnt <= slow ? 2'h3 : 2'h0;
                readCount <= readCount + 1;
            end else if (busy && waitCnt == 2'h0) begin
                busy <= 1'b0;
                flashValid <= 1'b1;
                flashData <= addrReg[7:0] ^ addrReg[15:8] ^ 8'h3c;
            end else if (busy) begin
                waitCnt <= waitCnt - 2'h1;
            end
        end
    end
endmodule : crc_flash_model

// ==== dv/crc16_crc32_engine_tb.sv ====
// Self-checking testbench of the CRC unit
`timescale 1ns/10ps
module crc16_crc32_engine_tb;
    import crc_pkg::*;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  sfrAddr = 8'h00;
    logic        sfrWrite = 1'b0;
    logic        sfrRead = 1'b0;
    logic [7:0]  sfrWdata = 8'h00;
    logic        slow = 1'b0;
    logic [7:0]  sfrRdata, flashData;
    logic        sfrReady, cpuStall, flashRead, flashValid;
    logic [15:0] flashAddr;
    logic [31:0] modelAcc;
    logic        modelP16;
    int          readCount;
    int          failCount = 0;
    int          compares = 0;
    int          cycles = 0;

    always #4 clk = ~clk;

    crc_unit #(.FIFO_DEPTH(16)) i_crc_unit (
        .clk(clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
        .sfrReady(sfrReady), .cpuStall(cpuStall), .flashRead(flashRead),
        .flashAddr(flashAddr), .flashValid(flashValid), .flashData(flashData));

    crc_flash_model i_crc_flash_model (
        .clk(clk), .resetn(resetn), .slow(slow), .flashRead(flashRead),
        .flashAddr(flashAddr), .flashValid(flashValid), .flashData(flashData),
        .readCount(readCount));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clk);
        sfrRead = 1'b0;
        @(negedge clk);
        d = sfrRdata;
    endtask : rd

    task automatic waitIdle(input int limit);
        int n;
        n = 0;
        while (cpuStall !== 1'b0 && n < limit) begin
            @(negedge clk);
            n++;
        end
        chk("stall clear", 32'h0, {31'h0, cpuStall});
    endtask : waitIdle

    function automatic logic [31:0] crcStep(logic [31:0] acc, logic [7:0] b, logic p16);
        if (p16) begin
            acc[15:8] ^= b;
            for (int i = 0; i < 8; i++)
                acc[15:0] = acc[15] ? {acc[14:0], 1'b0} ^ POLY16 : {acc[14:0], 1'b0};
        end else begin
            acc[7:0] ^= b;
            for (int i = 0; i < 8; i++)
                acc = acc[0] ? (acc >> 1) ^ POLY32_REFLECTED : acc >> 1;
        end
        return acc;
    endfunction : crcStep

    task automatic setup(input logic p16, input logic ones);
        wr(CRC_CONTROL_ADDR, {3'b000, p16, 1'b0, ones, 2'b00});
        wr(CRC_CONTROL_ADDR, {3'b000, p16, 1'b1, ones, 2'b00});
        modelP16 = p16;
        modelAcc = ones ? (p16 ? 32'h0000ffff : INIT_ONES) : INIT_ZEROS;
    endtask : setup

    task automatic feed(input logic [7:0] b);
        wr(CRC_INPUT_ADDR, b);
        modelAcc = crcStep(modelAcc, b, modelP16);
    endtask : feed

    task automatic getRes(output logic [31:0] r);
        logic [7:0] b;
        waitIdle(100);
        for (int i = 0; i < 4; i++) begin
            rd(CRC_RESULT_ADDR, b);
            r[8*i +: 8] = b;
        end
    endtask : getRes

    task automatic chkRes(input string what);
        logic [31:0] r;
        getRes(r);
        chk(what, modelP16 ? {2{modelAcc[15:0]}} : modelAcc, r);
    endtask : chkRes

    task automatic t_reset();
        logic [7:0]  b;
        logic [31:0] r;
        rd(CRC_CONTROL_ADDR, b);
        chk("control reset", {24'h0, CTL_RESET}, {24'h0, b});
        rd(8'h00, b);
        chk("unmapped read", 32'h0, {24'h0, b});
        chk("ready", 32'h1, {31'h0, sfrReady});
        getRes(r);
        chk("result reset", RESULT_RESET, r);
        $display("test reset done");
    endtask : t_reset

    task automatic t_crc();
        logic [31:0] r;
        setup(1'b0, 1'b1);
        feed(8'h63);
        getRes(r);
        chk("crc32 one byte", 32'hf9462090, r);
        setup(1'b0, 1'b1);
        feed(8'haa);
        feed(8'hbb);
        feed(8'hcc);
        chkRes("crc32 three bytes");
        chkRes("crc32 held");
        setup(1'b1, 1'b1);
        feed(8'h63);
        getRes(r);
        chk("crc16 one byte", 32'hbd35bd35, r);
        setup(1'b1, 1'b0);
        feed(8'h00);
        feed(8'h00);
        feed(8'haa);
        feed(8'hbb);
        feed(8'hcc);
        chkRes("crc16 zero start");
        $display("test crc done");
    endtask : t_crc

    task automatic t_ctl();
        logic [7:0] b;
        wr(CRC_CONTROL_ADDR, 8'hff);
        rd(CRC_CONTROL_ADDR, b);
        chk("control fields", 32'h17, {24'h0, b});
        rd(CRC_RESULT_ADDR, b);
        chk("aliased byte", 32'hff, {24'h0, b});
        rd(CRC_CONTROL_ADDR, b);
        chk("pointer wrap", 32'h14, {24'h0, b});
        setup(1'b0, 1'b0);
        for (int i = 0; i < 4; i++)
            wr(CRC_RESULT_ADDR, 8'(8'h11 * (i + 1)));
        modelAcc = 32'h44332211;
        chkRes("result written");
        feed(8'h5a);
        chkRes("after overwrite");
        $display("test control done");
    endtask : t_ctl

    task automatic t_auto(input logic s, input logic [6:0] page);
        int          base;
        logic [15:0] a;
        slow = s;
        setup(1'b0, 1'b1);
        wr(CRC_AUTO_ADDR, {1'b1, page});
        wr(CRC_COUNT_ADDR, 8'h01);
        base = readCount;
        wr(CRC_CONTROL_ADDR, 8'h04);
        chk("stall in run", 32'h1, {31'h0, cpuStall});
        while (flashRead !== 1'b1) @(negedge clk);
        chk("first address", {16'h0, page, 9'h000}, {16'h0, flashAddr});
        for (int i = 0; i < SECTOR_BYTES; i++) begin
            a = 16'(page * SECTOR_BYTES + i);
            modelAcc = crcStep(modelAcc, a[7:0] ^ a[15:8] ^ 8'h3c, 1'b0);
        end
        waitIdle(5000);
        chk("flash reads", SECTOR_BYTES, readCount - base);
        wr(CRC_AUTO_ADDR, {1'b0, page});
        chkRes("auto result");
        $display("test auto done");
    endtask : t_auto

    task automatic t_abort();
        logic [7:0] b;
        setup(1'b0, 1'b1);
        wr(CRC_AUTO_ADDR, 8'h83);
        wr(CRC_COUNT_ADDR, 8'h01);
        wr(CRC_CONTROL_ADDR, 8'h04);
        repeat (20) @(negedge clk);
        resetn = 1'b0;
        @(negedge clk);
        chk("stall in reset", 32'h0, {31'h0, cpuStall});
        resetn = 1'b1;
        rd(CRC_AUTO_ADDR, b);
        chk("auto after abort", 32'h0, {24'h0, b});
        rd(CRC_CONTROL_ADDR, b);
        chk("control after abort", {24'h0, CTL_RESET}, {24'h0, b});
        chk("no request after abort", 32'h0, {31'h0, flashRead});
        $display("test abort done");
    endtask : t_abort

    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, failCount);
        if (failCount == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            $display("[ERR] timeout expected below %0d cycles seen %0d", 20000, cycles);
            conclude();
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_crc();
        t_ctl();
        t_auto(1'b0, 7'd1);
        t_auto(1'b1, 7'd2);
        t_abort();
        conclude();
    end
endmodule : crc16_crc32_engine_tb
